// File: hdl/ssr_status.sv
// Status reporting, service request and output queue logic.
// Assumes synchronous inputs, one command per cycle, nonvolatile values stable at reset release.
// Contract
// - Standard event latch records events, is read only, clears when read.
// - Standard event mask written and read by commands, cleared at power on if psc is 1.
// - Enabled standard event bits OR into the event summary bit.
// - Poll and query return same byte except bit 6: query master summary, poll request flag.
// - Master summary is an unlatched OR of status bits enabled by service request mask.
// - Reading the status byte by query clears nothing.
// - Requesting service raises the request line and latches the flag into bit 6.
// - Serial poll returns the flag in bit 6, then clears it, other bits untouched.
// - Output queue is a byte FIFO; bit 4 set while it holds a byte.
// - An error message offered while the output queue is full produces an overflow error report.
// - Output queue emptied at power on and by clear status.
// - Service request from masked status bits; zero mask never requests.
// - Active inhibit pin produces remote inhibit event in questionable group.
// - Remote inhibit event can request service and drive the fault output.
// - Fault output driven from selectable questionable, operation or standard event.
// - Power on: filters, latches, group masks, status byte and queue initialised.
// - With psc 0 both masks restored from nonvolatile storage, else cleared.
// - Power-on flag bit 7 set each power-up, feeds event summary bit 5.
// - Standard event bits: 0,2,3,4,5,7 as completion, errors and power on.
// - Status bit 7 is the operation group summary.
// - Status bit 3 is the questionable group summary.
// - Group events latch filtered transitions, cleared by read or clear status.

module ssr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ssr_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_group,
  input wire logic [15:0] cmd_data,
  output logic resp_valid,
  output logic [15:0] resp_data,
  input wire logic [15:0] oper_cond,
  input wire logic [15:0] ques_cond,
  input wire logic [7:0] std_event_set,
  input wire logic inhibit_input_pin,
  input wire logic msg_valid,
  input wire logic [7:0] msg_data,
  input wire logic msg_is_error,
  output logic msg_ready,
  output logic srq,
  output logic fault_output_pin,
  output logic queue_overflow,
  input wire logic nv_psc,
  input wire logic [7:0] nv_std_mask,
  input wire logic [7:0] nv_srq_mask,
  output logic save_psc,
  output logic [7:0] save_std_mask,
  output logic [7:0] save_srq_mask
);
  ssr_pkg::ssr_init_t init_q;
  logic [7:0] sev_latch_q;
  logic [7:0] std_mask_q;
  logic [7:0] srq_mask_q;
  logic psc_q;
  logic rqs_q;
  logic mss_prev_q;
  logic ovf_q;
  logic fault_q;
  logic [6:0] fault_sel_q;
  logic resp_valid_q;
  logic [15:0] resp_data_q;
  logic [15:0] cond_w [2];
  logic [15:0] event_w [2];
  logic [1:0] grp_sum;
  logic [7:0] stb_base;
  logic mss;
  logic esb;
  logic mav;
  logic cls;
  logic [8:0] fifo_out;
  logic queue_pop;

  assign cls = cmd_valid && (cmd_code == ssr_pkg::CMD_CLEAR_STATUS);
  assign queue_pop = cmd_valid && (cmd_code == ssr_pkg::CMD_RD_QUEUE);
  assign cond_w[ssr_pkg::GRP_OPER] = oper_cond;
  // Inhibit pin forms a questionable condition, so it passes the transition filters
  assign cond_w[ssr_pkg::GRP_QUES] = ques_cond | (inhibit_input_pin ? ssr_pkg::RI_BIT_MASK : 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Operation and questionable groups
  for (genvar g = 0; g < 2; g++) begin : grp_gen
    logic [15:0] prev_q;
    logic [15:0] ptr_q;
    logic [15:0] ntr_q;
    logic [15:0] mask_q;
    logic [15:0] event_q;
    logic sel;
    logic [15:0] set_w;
    assign sel = cmd_valid && (cmd_group == 1'(g));
    assign set_w = (cond_w[g] & ~prev_q & ptr_q) | (~cond_w[g] & prev_q & ntr_q);
    always_ff @(posedge clk) begin
      if (rst || (cmd_valid && cmd_code == ssr_pkg::CMD_STATUS_PRESET)) begin
        ptr_q <= ssr_pkg::PTR_RST;
        ntr_q <= ssr_pkg::NTR_RST;
        mask_q <= ssr_pkg::GRP_MASK_RST;
      end else if (sel) begin
        if (cmd_code == ssr_pkg::CMD_WR_PTR) ptr_q <= cmd_data;
        if (cmd_code == ssr_pkg::CMD_WR_NTR) ntr_q <= cmd_data;
        if (cmd_code == ssr_pkg::CMD_WR_GRP_MASK) mask_q <= cmd_data;
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        prev_q <= 16'h0000;
        event_q <= 16'h0000;
      end else begin
        prev_q <= cond_w[g];
        // A transition in the clearing cycle survives the clear
        event_q <= ((cls || (sel && cmd_code == ssr_pkg::CMD_RD_GRP_EVENT)) ? 16'h0000 : event_q) | set_w;
      end
    end
    assign event_w[g] = event_q;
    assign grp_sum[g] = |(event_q & mask_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standard event latch and masks
  always_ff @(posedge clk) begin
    if (rst) begin
      sev_latch_q <= ssr_pkg::SEV_LATCH_RST;
    end else begin
      sev_latch_q <= ((cls || (cmd_valid && cmd_code == ssr_pkg::CMD_RD_STD_LATCH)) ? 8'h00 : sev_latch_q)
                     | (std_event_set & ssr_pkg::SEV_EXT_MASK);
    end
  end

  // Nonvolatile values are taken one edge after reset release, never under reset
  always_ff @(posedge clk) begin
    if (rst) begin
      init_q <= ssr_pkg::SSR_INIT_LOAD;
      psc_q <= 1'b1;
      std_mask_q <= ssr_pkg::MASK8_RST;
      srq_mask_q <= ssr_pkg::MASK8_RST;
    end else begin
      unique case (init_q)
        ssr_pkg::SSR_INIT_LOAD: begin
          init_q <= ssr_pkg::SSR_INIT_RUN;
          psc_q <= nv_psc;
          std_mask_q <= nv_psc ? ssr_pkg::MASK8_RST : nv_std_mask;
          srq_mask_q <= nv_psc ? ssr_pkg::MASK8_RST : (nv_srq_mask & ssr_pkg::SRQ_MASK_WR);
        end
        ssr_pkg::SSR_INIT_RUN: begin
          if (cmd_valid && cmd_code == ssr_pkg::CMD_WR_STD_MASK) std_mask_q <= cmd_data[7:0];
          if (cmd_valid && cmd_code == ssr_pkg::CMD_WR_SRQ_MASK) srq_mask_q <= cmd_data[7:0] & ssr_pkg::SRQ_MASK_WR;
          if (cmd_valid && cmd_code == ssr_pkg::CMD_WR_PSC) psc_q <= cmd_data[0];
        end
      endcase
    end
  end

  assign save_psc = psc_q;
  assign save_std_mask = std_mask_q;
  assign save_srq_mask = srq_mask_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte, master summary and request flag
  assign esb = |(sev_latch_q & std_mask_q);
  assign stb_base = {grp_sum[ssr_pkg::GRP_OPER], 1'b0, esb, mav, grp_sum[ssr_pkg::GRP_QUES], 3'b000};
  assign mss = |(stb_base & srq_mask_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      rqs_q <= 1'b0;
      mss_prev_q <= 1'b0;
    end else begin
      mss_prev_q <= mss;
      // New reason wins over a poll in the same cycle so no request is lost
      if (mss && !mss_prev_q) begin
        rqs_q <= 1'b1;
      end else if ((cmd_valid && cmd_code == ssr_pkg::CMD_SERIAL_POLL) || cls) begin
        rqs_q <= 1'b0;
      end
    end
  end

  assign srq = rqs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output queue
  ssr_fifo #(.WIDTH(ssr_pkg::MSG_W + 1), .DEPTH(ssr_pkg::FIFO_DEPTH)) u_queue (
    .clk(clk),
    .rst(rst),
    .flush(cls),
    .in_valid(msg_valid),
    .in_ready(msg_ready),
    .in_data({msg_is_error, msg_data}),
    .out_valid(mav),
    .out_ready(queue_pop),
    .out_data(fifo_out)
  );

  // An error that finds the queue full sets the overflow report, which holds until clear status
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= (ovf_q && !cls) || (msg_valid && msg_is_error && !msg_ready);
    end
  end

  assign queue_overflow = ovf_q;

  ////////////////////////////////////////////////////////////////////////////
  // Discrete fault output
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_sel_q <= ssr_pkg::FAULT_SEL_RST;
      fault_q <= 1'b0;
    end else begin
      if (cmd_valid && cmd_code == ssr_pkg::CMD_WR_FAULT_SEL) fault_sel_q <= cmd_data[6:0];
      unique case (fault_sel_q[5:4])
        ssr_pkg::FLT_SRC_OPER: fault_q <= fault_sel_q[6] && event_w[ssr_pkg::GRP_OPER][fault_sel_q[3:0]];
        ssr_pkg::FLT_SRC_QUES: fault_q <= fault_sel_q[6] && event_w[ssr_pkg::GRP_QUES][fault_sel_q[3:0]];
        ssr_pkg::FLT_SRC_STD: fault_q <= fault_sel_q[6] && sev_latch_q[fault_sel_q[2:0]];
        default: fault_q <= 1'b0;
      endcase
    end
  end

  assign fault_output_pin = fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command answers, one cycle after the command
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_data_q <= 16'h0000;
    end else begin
      resp_valid_q <= 1'b0;
      if (cmd_valid) begin
        resp_valid_q <= 1'b1;
        unique case (cmd_code)
          ssr_pkg::CMD_RD_STD_MASK: resp_data_q <= {8'h00, std_mask_q};
          ssr_pkg::CMD_RD_STD_LATCH: resp_data_q <= {8'h00, sev_latch_q};
          ssr_pkg::CMD_RD_SRQ_MASK: resp_data_q <= {8'h00, srq_mask_q};
          ssr_pkg::CMD_RD_STB_QUERY: resp_data_q <= {8'h00, stb_base[7], mss, stb_base[5:0]};
          ssr_pkg::CMD_SERIAL_POLL: resp_data_q <= {8'h00, stb_base[7], rqs_q, stb_base[5:0]};
          ssr_pkg::CMD_RD_QUEUE: resp_data_q <= mav ? {8'h00, fifo_out[7:0]} : 16'h0000;
          ssr_pkg::CMD_RD_GRP_EVENT: resp_data_q <= event_w[cmd_group];
          default: begin
            resp_valid_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp_data = resp_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_LATCH_READ_CLEARS: assert property (
    cmd_valid && cmd_code == ssr_pkg::CMD_RD_STD_LATCH |=> sev_latch_q == ($past(std_event_set) & ssr_pkg::SEV_EXT_MASK))
    else $error("standard event latch not cleared by read");
  AST_PSC_CLEARS_MASKS: assert property (
    init_q == ssr_pkg::SSR_INIT_LOAD && nv_psc |=> std_mask_q == 8'h00 && srq_mask_q == 8'h00)
    else $error("masks not cleared at power on");
  AST_RESTORE_MASKS: assert property (
    init_q == ssr_pkg::SSR_INIT_LOAD && !nv_psc |=> std_mask_q == $past(nv_std_mask) && !psc_q)
    else $error("masks not restored at power on");
  AST_POLL_SUMMARY: assert property (
    cmd_valid && cmd_code == ssr_pkg::CMD_SERIAL_POLL |=> resp_data[5] == $past(|(sev_latch_q & std_mask_q)))
    else $error("event summary bit wrong in poll answer");
  AST_QUERY_BIT6: assert property (
    cmd_valid && cmd_code == ssr_pkg::CMD_RD_STB_QUERY |=> resp_valid && resp_data[6] == $past(mss)
    && resp_data[2:0] == 3'b000)
    else $error("query answer bit 6 is not the master summary");
  AST_ZERO_MASK_NO_REQ: assert property (
    srq_mask_q == 8'h00 && !srq |=> !srq)
    else $error("request raised with zero mask");
  AST_QUERY_KEEPS_FLAG: assert property (
    cmd_valid && cmd_code == ssr_pkg::CMD_RD_STB_QUERY && rqs_q |=> rqs_q)
    else $error("query cleared the request flag");
  AST_REQ_RAISES_SRQ: assert property (
    $rose(mss) |=> srq && rqs_q)
    else $error("new reason did not raise request");
  AST_POLL_CLEARS_FLAG: assert property (
    cmd_valid && cmd_code == ssr_pkg::CMD_SERIAL_POLL && !(mss && !mss_prev_q) |=> !srq ##0 resp_data[6] == $past(rqs_q))
    else $error("poll did not return and clear request flag");
  AST_MAV_ON_PUSH: assert property (
    msg_valid && msg_ready && !cls |=> mav)
    else $error("message available not set after push");
  AST_OVERFLOW_REPORT: assert property (
    msg_valid && msg_is_error && !msg_ready |=> queue_overflow ##1 (queue_overflow || $past(cls)))
    else $error("queue overflow not reported");
  AST_CLS_EMPTIES: assert property (
    cls |=> !mav && msg_ready)
    else $error("clear status did not empty queue");
  AST_INHIBIT_EVENT: assert property (
    $rose(inhibit_input_pin) && grp_gen[1].ptr_q[9] && !$past(ques_cond[9]) |=> grp_gen[1].event_q[9])
    else $error("inhibit did not latch questionable event");
  AST_PON_FLAG: assert property (
    init_q == ssr_pkg::SSR_INIT_LOAD |-> sev_latch_q[ssr_pkg::SEV_PON])
    else $error("power-on flag not set after reset");
  AST_FAULT_FOLLOWS: assert property (
    !fault_sel_q[6] |=> !fault_output_pin)
    else $error("fault output active while disabled");
  AST_QUES_READ_CLEARS: assert property (
    cmd_valid && cmd_code == ssr_pkg::CMD_RD_GRP_EVENT && cmd_group |=> grp_gen[1].event_q == $past(grp_gen[1].set_w))
    else $error("questionable event latch not cleared by read");
  AST_STD_MASK_WRITE: assert property (
    init_q == ssr_pkg::SSR_INIT_RUN && cmd_valid && cmd_code == ssr_pkg::CMD_WR_STD_MASK
    |=> std_mask_q == $past(cmd_data[7:0]))
    else $error("standard event mask write lost");

  COV_POLL_WITH_REQ: cover property (cmd_valid && cmd_code == ssr_pkg::CMD_SERIAL_POLL && rqs_q);
  COV_QUEUE_FULL: cover property (msg_valid && !msg_ready);
  COV_FAULT_ON: cover property ($rose(fault_output_pin));
  COV_RESTORE: cover property (init_q == ssr_pkg::SSR_INIT_LOAD && !nv_psc);
  COV_OVERFLOW: cover property ($rose(queue_overflow));
endmodule

// File: common/ssr_pkg.sv
// Constants for the status and service request block.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package ssr_pkg;
  localparam int unsigned GRP_W = 16;
  localparam int unsigned MSG_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CLK_HZ = 20000000;
  ////////////////////////////////////////////////////////////////////////////
  // Common command codes on cmd_code
  localparam logic [3:0] CMD_WR_STD_MASK = 4'h0;
  localparam logic [3:0] CMD_RD_STD_MASK = 4'h1;
  localparam logic [3:0] CMD_RD_STD_LATCH = 4'h2;
  localparam logic [3:0] CMD_WR_SRQ_MASK = 4'h3;
  localparam logic [3:0] CMD_RD_SRQ_MASK = 4'h4;
  localparam logic [3:0] CMD_RD_STB_QUERY = 4'h5;
  localparam logic [3:0] CMD_SERIAL_POLL = 4'h6;
  localparam logic [3:0] CMD_CLEAR_STATUS = 4'h7;
  localparam logic [3:0] CMD_WR_PSC = 4'h8;
  localparam logic [3:0] CMD_RD_QUEUE = 4'h9;
  localparam logic [3:0] CMD_WR_PTR = 4'hA;
  localparam logic [3:0] CMD_WR_NTR = 4'hB;
  localparam logic [3:0] CMD_WR_GRP_MASK = 4'hC;
  localparam logic [3:0] CMD_RD_GRP_EVENT = 4'hD;
  localparam logic [3:0] CMD_WR_FAULT_SEL = 4'hE;
  localparam logic [3:0] CMD_STATUS_PRESET = 4'hF;
  ////////////////////////////////////////////////////////////////////////////
  // Status byte bit positions
  localparam int unsigned STB_QUES = 3;
  localparam int unsigned STB_MAV = 4;
  localparam int unsigned STB_ESB = 5;
  localparam int unsigned STB_RQS = 6;
  localparam int unsigned STB_OPER = 7;
  // Standard event latch bit positions
  localparam int unsigned SEV_OPC = 0;
  localparam int unsigned SEV_QYE = 2;
  localparam int unsigned SEV_DDE = 3;
  localparam int unsigned SEV_EXE = 4;
  localparam int unsigned SEV_CME = 5;
  localparam int unsigned SEV_PON = 7;
  localparam logic [7:0] SEV_EXT_MASK = 8'h3D;
  localparam logic [7:0] SRQ_MASK_WR = 8'hB8;
  // Group indices and remote inhibit position in the questionable group
  localparam int unsigned GRP_OPER = 0;
  localparam int unsigned GRP_QUES = 1;
  localparam logic [15:0] RI_BIT_MASK = 16'h0200;
  localparam logic [1:0] FLT_SRC_OPER = 2'h0;
  localparam logic [1:0] FLT_SRC_QUES = 2'h1;
  localparam logic [1:0] FLT_SRC_STD = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] PTR_RST = 16'hFFFF;
  localparam logic [15:0] NTR_RST = 16'h0000;
  localparam logic [15:0] GRP_MASK_RST = 16'h0000;
  localparam logic [7:0] SEV_LATCH_RST = 8'h80;
  localparam logic [7:0] MASK8_RST = 8'h00;
  localparam logic [6:0] FAULT_SEL_RST = 7'h00;
  typedef enum logic {SSR_INIT_LOAD, SSR_INIT_RUN} ssr_init_t;
endpackage

// File: hdl/ssr_fifo_note.sv
// Holds no logic: the output queue sits beside the status block.

// File: bench/ssr_ctrl_model.sv
// Bus controller model: passes bench commands on and serial-polls on request.
// Assumes reads are answered one cycle after the command is taken.
module ssr_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] go_code,
  input wire logic go_group,
  input wire logic [15:0] go_data,
  input wire logic auto_poll,
  input wire logic [7:0] poll_delay,
  input wire logic srq,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic cmd_group,
  output logic [15:0] cmd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    cmd_valid <= 1'b0;
    // Idle code and data lines keep changing so nothing leans on stale values; cmd_group holds
    cmd_code <= ~cmd_code;
    cmd_data <= ~cmd_data;
    if (rst) begin
      cmd_code <= 4'h0;
      cmd_group <= 1'b0;
      cmd_data <= 16'h0000;
    end else if (go) begin
      cmd_valid <= 1'b1;
      cmd_code <= go_code;
      cmd_group <= go_group;
      cmd_data <= go_data;
    end else if (auto_poll && srq && wait_q == poll_delay) begin
      cmd_valid <= 1'b1;
      cmd_code <= ssr_pkg::CMD_SERIAL_POLL;
    end
  end
  // Service delay; poll_delay of at least 1 keeps one poll per request
  always_ff @(posedge clk) begin
    if (rst || !srq || !auto_poll || wait_q == poll_delay)
      wait_q <= 8'h00;
    else
      wait_q <= wait_q + 8'h01;
  end
endmodule

// File: bench/ssr_status_bench.sv
// Self-checking bench for the status and service request block.
// Assumes the controller model in the same folder drives the command port.
module ssr_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, go_group = 1'b0, auto_poll = 1'b0, inhibit_input_pin = 1'b0;
  logic msg_valid = 1'b0, msg_is_error = 1'b0, nv_psc = 1'b1;
  logic [3:0] go_code = 4'h0;
  logic [7:0] poll_delay = 8'h02, std_event_set = 8'h00, msg_data = 8'h00, nv_std_mask = 8'hFF, nv_srq_mask = 8'hFF;
  logic [15:0] go_data = 16'h0000, oper_cond = 16'h0000, ques_cond = 16'h0000, rsp;
  logic cmd_valid, cmd_group, resp_valid, msg_ready, srq, fault_output_pin, queue_overflow, save_psc;
  logic [3:0] cmd_code;
  logic [7:0] save_std_mask, save_srq_mask;
  logic [15:0] cmd_data, resp_data;
  logic [31:0] lf = 32'h00000CDC;
  logic [7:0] q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  ssr_status u_ssr_status (.clk, .rst, .cmd_valid, .cmd_code, .cmd_group, .cmd_data, .resp_valid, .resp_data,
    .oper_cond, .ques_cond, .std_event_set, .inhibit_input_pin, .msg_valid, .msg_data, .msg_is_error,
    .msg_ready, .srq, .fault_output_pin, .queue_overflow, .nv_psc, .nv_std_mask, .nv_srq_mask, .save_psc,
    .save_std_mask, .save_srq_mask);
  ssr_ctrl_model u_ssr_ctrl_model (.clk, .rst, .go, .go_code, .go_group, .go_data, .auto_poll, .poll_delay,
    .srq, .cmd_valid, .cmd_code, .cmd_group, .cmd_data);
  initial begin
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected status byte; bits 2..0 are always zero
  function automatic logic [15:0] stb(input logic op, input logic b6, input logic esb, input logic mav,
                                      input logic qs);
    return {8'h00, op, b6, esb, mav, qs, 3'b000};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One command through the model; a missing answer leaves a marker value in rsp
  task automatic cmd(input logic [3:0] c, input logic g, input logic [15:0] d);
    go <= 1'b1;
    go_code <= c;
    go_group <= g;
    go_data <= d;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1 rsp = (resp_valid === 1'b1) ? resp_data : 16'hBAD0;
    @(posedge clk);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmd(ssr_pkg::CMD_RD_STD_LATCH, 1'b0, 16'h0000);
    chk(rsp, 16'h0080);
    cmd(ssr_pkg::CMD_RD_STD_LATCH, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    cmd(ssr_pkg::CMD_RD_STD_MASK, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    cmd(ssr_pkg::CMD_RD_SRQ_MASK, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    // Random masks and events; unused event bits must not latch
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      cmd(ssr_pkg::CMD_WR_STD_MASK, 1'b0, {8'h00, lf[15:8]});
      std_event_set <= lf[7:0];
      @(posedge clk);
      std_event_set <= 8'h00;
      cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
      chk(rsp, stb(1'b0, 1'b0, |(lf[7:0] & ssr_pkg::SEV_EXT_MASK & lf[15:8]), 1'b0, 1'b0));
      chk({15'h0000, srq}, 16'h0000);
      cmd(ssr_pkg::CMD_RD_STD_MASK, 1'b0, 16'h0000);
      chk(rsp, {8'h00, lf[15:8]});
      cmd(ssr_pkg::CMD_RD_STD_LATCH, 1'b0, 16'h0000);
      chk(rsp, {8'h00, lf[7:0] & ssr_pkg::SEV_EXT_MASK});
    end
    cmd(ssr_pkg::CMD_WR_SRQ_MASK, 1'b0, 16'h00FF);
    cmd(ssr_pkg::CMD_RD_SRQ_MASK, 1'b0, 16'h0000);
    chk(rsp, 16'h00B8);
    cmd(ssr_pkg::CMD_WR_STD_MASK, 1'b0, 16'h0001);
    std_event_set <= 8'h01;
    @(posedge clk);
    std_event_set <= 8'h00;
    repeat (3) @(posedge clk);
    chk({15'h0000, srq}, 16'h0001);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, stb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, stb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
    cmd(ssr_pkg::CMD_SERIAL_POLL, 1'b0, 16'h0000);
    chk(rsp, stb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
    cmd(ssr_pkg::CMD_SERIAL_POLL, 1'b0, 16'h0000);
    chk(rsp, stb(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    chk({15'h0000, srq}, 16'h0000);
    cmd(ssr_pkg::CMD_RD_STD_LATCH, 1'b0, 16'h0000);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    // Remote inhibit into questionable group, fault pin and a slow poll
    cmd(ssr_pkg::CMD_WR_GRP_MASK, 1'b1, ssr_pkg::RI_BIT_MASK);
    cmd(ssr_pkg::CMD_WR_FAULT_SEL, 1'b0, 16'h0059);
    poll_delay <= 8'h07;
    auto_poll <= 1'b1;
    inhibit_input_pin <= 1'b1;
    rsp = 16'h0000;
    for (int w = 0; w < 40 && rsp[6] !== 1'b1; w++) begin
      @(posedge clk);
      #1 if (resp_valid === 1'b1) rsp = resp_data;
    end
    chk(rsp, stb(1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
    chk({15'h0000, fault_output_pin}, 16'h0001);
    @(posedge clk);
    auto_poll <= 1'b0;
    chk({15'h0000, srq}, 16'h0000);
    cmd(ssr_pkg::CMD_RD_GRP_EVENT, 1'b1, 16'h0000);
    chk(rsp, ssr_pkg::RI_BIT_MASK);
    #1 chk({15'h0000, fault_output_pin}, 16'h0000);
    @(posedge clk);
    inhibit_input_pin <= 1'b0;
    @(posedge clk);
    // Operation group: rises filtered out, falls pass the negative filter
    lf = lfsr(lf);
    cmd(ssr_pkg::CMD_WR_GRP_MASK, 1'b0, 16'hFFFF);
    cmd(ssr_pkg::CMD_WR_PTR, 1'b0, 16'h0000);
    cmd(ssr_pkg::CMD_WR_NTR, 1'b0, lf[15:0] | 16'h0400);
    oper_cond <= lf[31:16] | lf[15:0] | 16'h0400;
    @(posedge clk);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    oper_cond <= 16'h0000;
    @(posedge clk);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, stb(1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
    cmd(ssr_pkg::CMD_RD_GRP_EVENT, 1'b0, 16'h0000);
    chk(rsp, lf[15:0] | 16'h0400);
    // Preset puts the filters back: a rise latches, a fall does not
    cmd(ssr_pkg::CMD_STATUS_PRESET, 1'b0, 16'h0000);
    oper_cond <= 16'h0400;
    @(posedge clk);
    oper_cond <= 16'h0000;
    cmd(ssr_pkg::CMD_RD_GRP_EVENT, 1'b0, 16'h0000);
    chk(rsp, 16'h0400);
    // Fill the queue until it refuses, then an error byte overflows it
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      q.push_back(lf[7:0]);
      msg_valid <= 1'b1;
      msg_data <= lf[7:0];
      msg_is_error <= i[0];
      @(posedge clk);
    end
    msg_is_error <= 1'b1;
    @(posedge clk);
    msg_valid <= 1'b0;
    @(posedge clk);
    #1 chk({15'h0000, msg_ready}, 16'h0000);
    chk({15'h0000, queue_overflow}, 16'h0001);
    @(posedge clk);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, stb(1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
    for (int i = 0; i < 16; i++) begin
      cmd(ssr_pkg::CMD_RD_QUEUE, 1'b0, 16'h0000);
      chk(rsp, {8'h00, q.pop_front()});
    end
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    msg_valid <= 1'b1;
    msg_data <= 8'hA5;
    repeat (2) @(posedge clk);
    msg_valid <= 1'b0;
    cmd(ssr_pkg::CMD_CLEAR_STATUS, 1'b0, 16'h0000);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    cmd(ssr_pkg::CMD_RD_QUEUE, 1'b0, 16'h0000);
    chk(rsp, 16'h0000);
    chk({14'h0000, srq, queue_overflow}, 16'h0000);
    // Power on with stored masks: the power-on flag must request service
    cmd(ssr_pkg::CMD_WR_PSC, 1'b0, 16'h0000);
    chk({15'h0000, save_psc}, 16'h0000);
    rst <= 1'b1;
    nv_psc <= 1'b0;
    nv_std_mask <= 8'h80;
    nv_srq_mask <= 8'h20;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    chk({15'h0000, srq}, 16'h0001);
    chk({save_std_mask, save_srq_mask}, 16'h8020);
    cmd(ssr_pkg::CMD_RD_STD_MASK, 1'b0, 16'h0000);
    chk(rsp, 16'h0080);
    cmd(ssr_pkg::CMD_RD_SRQ_MASK, 1'b0, 16'h0000);
    chk(rsp, 16'h0020);
    cmd(ssr_pkg::CMD_RD_STB_QUERY, 1'b0, 16'h0000);
    chk(rsp, stb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
    report_and_stop();
  end
endmodule
